// ### design/ddp_defines.svh
// constants for the direct cpu data port
`ifndef DDP_DEFINES_SVH
`define DDP_DEFINES_SVH
`define DDP_DATA_W 32
`define DDP_ADDR_W 32
`define DDP_PAR_W 4
`define DDP_LANE_W 8
`define DDP_BUF_DEPTH 2
`define DDP_CLK_PERIOD_NS 20
`define DDP_BUS_RELEASED 1'b1
`define DDP_INIT_RST_ACTIVE 1'b1
`define DDP_LANES_BYTE 4'h1
`define DDP_LANES_HALF 4'h3
`define DDP_LANES_TRI 4'h7
`define DDP_LANES_WORD 4'hf
`endif

// ### design/ddp_pkg.sv
// types shared by the direct cpu data port
`include "ddp_defines.svh"
package ddp_pkg;
  typedef enum logic [1:0] {
    DDP_SZ_BYTE = 2'b00,
    DDP_SZ_HALF = 2'b01,
    DDP_SZ_TRI = 2'b10,
    DDP_SZ_WORD = 2'b11
  } ddp_size_t;

  typedef enum logic [1:0] {
    DDP_OWN_NONE = 2'b00,
    DDP_OWN_CPU = 2'b01,
    DDP_OWN_MEM = 2'b10
  } ddp_owner_t;

  typedef struct packed {
    logic valid;
    logic store;
    ddp_size_t size;
    logic [`DDP_ADDR_W-1:0] addr;
    logic [`DDP_DATA_W-1:0] data;
    logic exc;
  } ddp_req_t;

  typedef struct packed {
    logic [`DDP_DATA_W-1:0] data;
    logic [`DDP_PAR_W-1:0] lanes;
  } ddp_load_t;
endpackage

// ### design/ddp_pipe_buf.sv
// small valid/ready buffer for captured load words
`timescale 1ns/10ps
`include "ddp_defines.svh"
module ddp_pipe_buf #(
  parameter int WIDTH = 36,
  parameter int DEPTH = `DDP_BUF_DEPTH
) (
  input wire logic i_clk, // system clock
  input wire logic i_sys_rst, // sync reset, active high
  input wire logic i_valid, // write side valid
  output logic o_ready, // write side ready
  input wire logic [WIDTH-1:0] i_data, // write data
  output logic o_valid, // read side valid
  input wire logic i_ready, // read side ready
  output logic [WIDTH-1:0] o_data // read data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] cnt_reg;
  logic push;
  logic pop;

  assign o_ready = (cnt_reg != FULL);
  assign o_valid = (cnt_reg != '0);
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;
  assign o_data = mem_reg[rd_ptr_reg];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_reg <= '0;
    end else if (push & ~pop) begin
      cnt_reg <= cnt_reg + 1'b1;
    end else if (pop & ~push) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule

// ### design/ddp_cpu_port.sv
// cpu end of the direct data port to on-chip memory
//
// Overview of operation
// - memory selected low means the bus interface unit ignores the request.
// - in MEM the cpu drives data for a store, memory for a load.
// - the data bus master also drives parity to a known value; no check.
// - the receiver captures the data bus at the end of MEM.
// - ALU stall shows stall low in that same ALU cycle; nobody latches then.
// - during any stall both sides repeat all address and control signals.
// - ALU exception raises request invalidate in MEM to block store latch.
// - MEM stall shows stall low in that same MEM cycle; data and parity repeated throughout.
// - transfers are full words; size code and low address pick lanes.
// - on reset the cpu raises memory init reset for the memory controller.
// - access issued in ALU, concluded in MEM; only ALU/MEM stalls matter.
// - RD stall postpones ALU signals; old bus driver repeats old data.
// - store stalled in MEM: cpu repeats data, memory writes any time.
// - exception before ALU withholds request valid for that instruction.
// - request invalidate stays high for a stall after an ALU exception.
// - MEM exception discards load data in WB; stores are unaffected.
// - direction high requests a store, low a load, with request valid.
// - next cycle's bus master raises its drive request: cpu for stores.
// - size code encodes byte, halfword, tribyte or word.
`timescale 1ns/10ps
`include "ddp_defines.svh"
module ddp_cpu_port #(
  parameter int BUF_DEPTH = `DDP_BUF_DEPTH
) (
  input wire logic i_clk, // system clock, 50 MHz
  input wire logic i_sys_rst, // sync reset, active high
  input wire ddp_pkg::ddp_req_t i_alu_req, // request entering ALU
  input wire logic i_pre_alu_exc, // exception before ALU
  input wire logic i_alu_exc, // exception in ALU cycle
  input wire logic i_mem_exc, // exception in MEM cycle
  input wire logic i_stall, // pipeline stall source
  output ddp_pkg::ddp_load_t o_load, // captured load word
  output logic o_load_valid, // load word available
  input wire logic i_load_ready, // load word taken
  output logic [`DDP_ADDR_W-1:0] o_data_address_bus, // access address
  output ddp_pkg::ddp_size_t o_access_size, // access size code
  output logic o_store_direction, // high store, low load
  output logic o_request_valid, // address valid
  output logic o_request_invalidate, // cancel in MEM
  output logic o_pipeline_stall_n, // stall, active low
  output logic o_memory_init_reset, // memory controller init
  input wire logic i_memory_selected_n, // memory hit, active low
  input wire logic [`DDP_DATA_W-1:0] i_cpu_data_bus, // data bus level
  output logic [`DDP_DATA_W-1:0] o_cpu_data_bus, // store data drive
  output logic o_cpu_data_bus_oe_n, // data drive enable, low
  output logic [`DDP_PAR_W-1:0] o_data_parity_bus, // parity drive
  output logic o_data_parity_bus_oe_n, // parity enable, low
  input wire logic i_memory_drive_request, // memory will drive
  output logic o_cpu_drive_request, // cpu will drive
  output logic o_biu_respond // bus interface unit handles it
);
  import ddp_pkg::*;

  ddp_req_t alu_reg;
  ddp_req_t mem_reg;
  logic mem_sel_reg;
  logic inval_reg;
  logic init_rst_reg;
  ddp_owner_t owner_reg;
  ddp_owner_t owner_next;
  logic [`DDP_DATA_W-1:0] dout_reg;
  logic [`DDP_PAR_W-1:0] par_reg;
  logic [`DDP_PAR_W-1:0] par_next;
  logic alu_exc_now;
  logic load_pending;
  logic buf_in_ready;
  logic stall;
  logic advance;
  logic push;
  ddp_load_t load_word;

  function automatic logic [`DDP_PAR_W-1:0] lane_mask(
    input ddp_size_t sz,
    input logic [1:0] ofs
  );
    logic [`DDP_PAR_W-1:0] base;
    base = `DDP_LANES_WORD;
    unique case (sz)
      DDP_SZ_BYTE: base = `DDP_LANES_BYTE;
      DDP_SZ_HALF: base = `DDP_LANES_HALF;
      DDP_SZ_TRI: base = `DDP_LANES_TRI;
      DDP_SZ_WORD: base = `DDP_LANES_WORD;
    endcase
    return base << ofs;
  endfunction

  // stall is the pipeline's own plus back-pressure from the load buffer
  assign alu_exc_now = alu_reg.valid & (alu_reg.exc | i_alu_exc);
  assign load_pending = mem_reg.valid & ~mem_reg.store & mem_sel_reg
    & ~i_mem_exc;
  assign stall = i_stall | (load_pending & ~buf_in_ready);
  assign advance = ~stall;
  assign o_pipeline_stall_n = ~stall;
  assign push = load_pending & advance;

  // request pins follow the ALU stage register, except request invalidate, which follows inval_reg
  assign o_data_address_bus = alu_reg.addr;
  assign o_access_size = alu_reg.size;
  assign o_store_direction = alu_reg.store;
  assign o_request_valid = alu_reg.valid;
  assign o_request_invalidate = inval_reg;
  assign o_memory_init_reset = init_rst_reg;
  assign o_biu_respond = alu_reg.valid & i_memory_selected_n;
  assign o_cpu_drive_request = alu_reg.valid & alu_reg.store
    & ~i_memory_selected_n;
  assign o_cpu_data_bus = dout_reg;
  assign o_data_parity_bus = par_reg;

  always_comb begin
    unique case (owner_reg)
      DDP_OWN_CPU: o_cpu_data_bus_oe_n = ~`DDP_BUS_RELEASED;
      DDP_OWN_NONE: o_cpu_data_bus_oe_n = `DDP_BUS_RELEASED;
      DDP_OWN_MEM: o_cpu_data_bus_oe_n = `DDP_BUS_RELEASED;
      default: o_cpu_data_bus_oe_n = `DDP_BUS_RELEASED;
    endcase
  end
  assign o_data_parity_bus_oe_n = o_cpu_data_bus_oe_n;

  // per-lane even parity of the store word
  for (genvar g = 0; g < `DDP_PAR_W; g++) begin : g_par
    assign par_next[g] = ^alu_reg.data[g*`DDP_LANE_W +: `DDP_LANE_W];
  end

  always_comb begin
    owner_next = DDP_OWN_NONE;
    if (alu_reg.valid & alu_reg.store & ~i_memory_selected_n) begin
      owner_next = DDP_OWN_CPU;
    end else if (alu_reg.valid & ~alu_reg.store
        & i_memory_drive_request) begin
      owner_next = DDP_OWN_MEM;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      init_rst_reg <= `DDP_INIT_RST_ACTIVE;
    end else begin
      init_rst_reg <= ~`DDP_INIT_RST_ACTIVE;
    end
  end

  // ALU stage: issued in ALU, held for every stall cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      alu_reg <= '0;
    end else if (stall) begin
      alu_reg.exc <= alu_exc_now;
    end else begin
      alu_reg <= i_alu_req;
      alu_reg.valid <= i_alu_req.valid & ~i_pre_alu_exc;
      alu_reg.exc <= 1'b0;
    end
  end

  // MEM stage: concludes the access, held through a MEM stall
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mem_reg <= '0;
      mem_sel_reg <= 1'b0;
    end else if (advance) begin
      mem_reg <= alu_reg;
      mem_reg.exc <= alu_exc_now;
      mem_sel_reg <= alu_reg.valid & ~i_memory_selected_n;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      inval_reg <= 1'b0;
    end else if (advance) begin
      inval_reg <= alu_exc_now;
    end
  end // held while stalled

  // bus drive: previous owner repeats its word through any stall
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      owner_reg <= DDP_OWN_NONE;
    end else if (advance) begin
      owner_reg <= owner_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dout_reg <= '0;
      par_reg <= '0;
    end else if (advance & (owner_next == DDP_OWN_CPU)) begin
      dout_reg <= alu_reg.data;
      par_reg <= par_next;
    end
  end

  // load words with their valid lanes, captured at the end of MEM
  assign load_word.data = i_cpu_data_bus;
  assign load_word.lanes = lane_mask(mem_reg.size, mem_reg.addr[1:0]);

  ddp_pipe_buf #(
    .WIDTH($bits(ddp_load_t)),
    .DEPTH(BUF_DEPTH)
  ) u_load_buf (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_valid(push),
    .o_ready(buf_in_ready),
    .i_data(load_word),
    .o_valid(o_load_valid),
    .i_ready(i_load_ready),
    .o_data(o_load)
  );

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_issue_store;
    advance && alu_reg.valid && alu_reg.store && !i_memory_selected_n;
  endsequence

  sequence s_issue_req;
    advance && i_alu_req.valid && !i_pre_alu_exc;
  endsequence

  sequence s_held_stall;
    !o_pipeline_stall_n ##1 !o_pipeline_stall_n;
  endsequence

  a_store_drive: assert property (
    s_issue_store |=> !o_cpu_data_bus_oe_n
      && o_cpu_data_bus == $past(alu_reg.data))
    else $error("store data not driven in MEM");

  a_parity_known: assert property (
    !o_cpu_data_bus_oe_n |-> !o_data_parity_bus_oe_n
      && o_data_parity_bus[0] == ^o_cpu_data_bus[7:0]
      && o_data_parity_bus[3] == ^o_cpu_data_bus[31:24])
    else $error("parity not driven with data");

  a_load_capture: assert property (
    (push && !o_load_valid) |=> o_load_valid
      && o_load.data == $past(i_cpu_data_bus))
    else $error("load word not captured at end of MEM");

  a_no_latch_stall: assert property (
    (!o_pipeline_stall_n && !o_load_valid) |=> !o_load_valid)
    else $error("load latched during stall");

  a_stall_ctrl_held: assert property (
    !o_pipeline_stall_n |=> $stable(o_data_address_bus)
      && $stable(o_request_valid) && $stable(o_store_direction)
      && $stable(o_access_size))
    else $error("control not repeated in stall");

  a_inval_cause: assert property (
    (advance && alu_exc_now) |=> o_request_invalidate)
    else $error("invalidate missing after ALU exception");

  a_stall_bus_held: assert property (
    s_held_stall |-> $stable(o_cpu_data_bus)
      && $stable(o_cpu_data_bus_oe_n) && $stable(o_data_parity_bus))
    else $error("data bus not repeated in stall");

  a_init_reset: assert property (
    @(posedge i_clk) disable iff (1'b0)
    i_sys_rst |=> o_memory_init_reset)
    else $error("memory init reset not raised");

  a_pre_exc_block: assert property (
    (advance && i_pre_alu_exc) |=> !o_request_valid)
    else $error("request valid after early exception");

  a_inval_hold: assert property (
    (o_request_invalidate && !o_pipeline_stall_n) |=> o_request_invalidate)
    else $error("invalidate dropped during stall");

  a_mem_exc_drop: assert property (
    (mem_reg.valid && !mem_reg.store && i_mem_exc && !o_load_valid)
      |=> !o_load_valid)
    else $error("load kept despite MEM exception");

  a_direction: assert property (
    s_issue_req |=> o_request_valid
      && o_store_direction == $past(i_alu_req.store))
    else $error("direction does not follow request");

  a_drive_req: assert property (
    (o_cpu_drive_request && o_pipeline_stall_n) |=> !o_cpu_data_bus_oe_n)
    else $error("cpu drive request not followed by drive");

  a_mem_owns_bus: assert property (
    (i_memory_drive_request && o_request_valid && !o_store_direction
      && o_pipeline_stall_n) |=> o_cpu_data_bus_oe_n)
    else $error("cpu drives bus while memory masters load");
endmodule

// ### test/ddp_mem_model.sv
// behavioural on-chip data memory facing the cpu data port
`timescale 1ns/10ps
module ddp_mem_model #(
  parameter logic [15:0] HIT_PAGE = 16'h0000
) (
  input wire logic i_clk, // system clock
  input wire logic i_sys_rst, // sync reset, active high
  input wire logic [31:0] i_addr, // data address bus
  input wire logic i_req_valid, // request valid
  input wire logic i_store, // store direction
  input wire logic i_stall_n, // pipeline stall, low
  input wire logic i_invalidate, // request invalidate
  input wire logic [31:0] i_bus, // resolved data bus
  output logic o_selected_n, // memory hit, low
  output logic o_drive_req, // memory drives next cycle
  output logic [31:0] o_data, // load data drive
  output logic [3:0] o_par, // load parity drive
  output logic o_drive, // drivers on
  output logic [31:0] o_wr_data, // last word written
  output logic [7:0] o_wr_count // words written
);
  logic mem_load_reg;
  logic mem_store_reg;
  logic [31:0] mem_addr_reg;
  assign o_selected_n = ~(i_req_valid & (i_addr[31:16] == HIT_PAGE));
  assign o_drive_req = ~o_selected_n & ~i_store;
  assign o_drive = mem_load_reg;
  assign o_data = {mem_addr_reg[15:0], ~mem_addr_reg[15:0]};
  always_comb begin
    for (int i = 0; i < 4; i++) o_par[i] = ^o_data[8*i +: 8];
  end
  // stage registers freeze while stalled, so drive repeats
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mem_load_reg <= 1'b0;
      mem_store_reg <= 1'b0;
      mem_addr_reg <= 32'h0;
    end else if (i_stall_n) begin
      mem_load_reg <= ~o_selected_n & ~i_store;
      mem_store_reg <= ~o_selected_n & i_store;
      mem_addr_reg <= i_addr;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_wr_count <= 8'h0;
      o_wr_data <= 32'h0;
    end else if (mem_store_reg & i_stall_n & ~i_invalidate) begin
      o_wr_count <= o_wr_count + 8'h1;
      o_wr_data <= i_bus;
    end
  end
endmodule

// ### test/ddp_cpu_port_bench.sv
// self-checking bench for the cpu end of the direct data port
`timescale 1ns/10ps
module ddp_cpu_port_bench;
  import ddp_pkg::*;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  ddp_req_t i_alu_req = '0;
  logic i_pre_alu_exc = 1'b0;
  logic i_alu_exc = 1'b0;
  logic i_mem_exc = 1'b0;
  logic i_stall = 1'b0;
  logic i_load_ready = 1'b1;
  ddp_load_t o_load;
  ddp_size_t o_access_size;
  logic [31:0] o_data_address_bus, i_cpu_data_bus, o_cpu_data_bus;
  logic [31:0] mem_data, wr_data, last_bus = 32'h0;
  logic [3:0] o_data_parity_bus, mem_par;
  logic [7:0] wr_count;
  logic o_load_valid, o_store_direction, o_request_valid, o_biu_respond;
  logic o_request_invalidate, o_pipeline_stall_n, o_memory_init_reset;
  logic i_memory_selected_n, o_cpu_data_bus_oe_n, o_data_parity_bus_oe_n;
  logic i_memory_drive_request, o_cpu_drive_request, mem_drive;
  int mismatches = 0;
  int total_checks = 0;

  initial begin
    forever #10 i_clk = ~i_clk;
  end

  ddp_cpu_port #(.BUF_DEPTH(2)) dut (.i_clk, .i_sys_rst, .i_alu_req,
    .i_pre_alu_exc, .i_alu_exc, .i_mem_exc, .i_stall, .o_load, .o_load_valid,
    .i_load_ready, .o_data_address_bus, .o_access_size, .o_store_direction,
    .o_request_valid, .o_request_invalidate, .o_pipeline_stall_n,
    .o_memory_init_reset, .i_memory_selected_n, .i_cpu_data_bus,
    .o_cpu_data_bus, .o_cpu_data_bus_oe_n, .o_data_parity_bus,
    .o_data_parity_bus_oe_n, .i_memory_drive_request, .o_cpu_drive_request,
    .o_biu_respond);

  ddp_mem_model mem (.i_clk, .i_sys_rst, .i_addr(o_data_address_bus),
    .i_req_valid(o_request_valid), .i_store(o_store_direction),
    .i_stall_n(o_pipeline_stall_n), .i_invalidate(o_request_invalidate),
    .i_bus(i_cpu_data_bus), .o_selected_n(i_memory_selected_n),
    .o_drive_req(i_memory_drive_request), .o_data(mem_data), .o_par(mem_par),
    .o_drive(mem_drive), .o_wr_data(wr_data), .o_wr_count(wr_count));

  // released bus shows a changing pattern, never the last value
  always_comb begin
    if (!o_cpu_data_bus_oe_n) i_cpu_data_bus = o_cpu_data_bus;
    else if (mem_drive) i_cpu_data_bus = mem_data;
    else i_cpu_data_bus = ~last_bus;
  end
  always @(posedge i_clk) last_bus <= i_cpu_data_bus;

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  function automatic logic [3:0] par(input logic [31:0] d);
    for (int i = 0; i < 4; i++) par[i] = ^d[8*i +: 8];
  endfunction

  function automatic logic [31:0] rd_word(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction

  task automatic issue(input logic st, input ddp_size_t sz,
                       input logic [31:0] a, input logic [31:0] d);
    i_alu_req = '{valid: 1'b1, store: st, size: sz, addr: a, data: d,
                  exc: 1'b0};
    cyc(1);
    i_alu_req = '0;
  endtask

  task automatic alu_phase(input logic st, input ddp_size_t sz,
                           input logic [31:0] a, input int stl);
    for (int i = 0; i <= stl; i++) begin
      i_stall = (i < stl);
      #1;
      chk(o_request_valid, 1'b1);
      chk(o_store_direction, st);
      chk(o_access_size, sz);
      chk(o_data_address_bus, a);
      chk(o_biu_respond, 1'b0);
      chk(o_cpu_drive_request, st);
      chk(o_pipeline_stall_n, i >= stl);
      cyc(1);
    end
  endtask

  task automatic do_store(input logic [31:0] a, input logic [31:0] d,
                          input logic exc, input int astl, input int mstl);
    logic [7:0] cnt;
    cnt = wr_count;
    issue(1'b1, DDP_SZ_WORD, a, d);
    i_alu_exc = exc;
    alu_phase(1'b1, DDP_SZ_WORD, a, astl);
    i_alu_exc = 1'b0;
    for (int i = 0; i <= mstl; i++) begin
      i_stall = (i < mstl);
      #1;
      chk(o_cpu_data_bus_oe_n, 1'b0);
      chk(o_cpu_data_bus, d);
      chk(o_data_parity_bus, par(d));
      chk(o_data_parity_bus_oe_n, 1'b0);
      chk(mem_drive, 1'b0);
      chk(o_request_invalidate, exc);
      chk(o_pipeline_stall_n, i >= mstl);
      cyc(1);
    end
    chk(wr_count, cnt + {7'h0, !exc});
    if (!exc) chk(wr_data, d);
  endtask

  task automatic do_load(input logic [31:0] a, input ddp_size_t sz,
                         input int astl, input logic mexc);
    logic [3:0] m;
    m = sz == DDP_SZ_BYTE ? 4'h1 : sz == DDP_SZ_HALF ? 4'h3 :
        sz == DDP_SZ_TRI ? 4'h7 : 4'hf;
    issue(1'b0, sz, a, 32'h0);
    alu_phase(1'b0, sz, a, astl);
    i_mem_exc = mexc;
    chk(o_cpu_data_bus_oe_n, 1'b1);
    chk(mem_drive, 1'b1);
    chk(mem_par, par(rd_word(a)));
    chk(o_load_valid, 1'b0);
    cyc(1);
    i_mem_exc = 1'b0;
    chk(o_load_valid, !mexc);
    if (!mexc) chk(o_load, {rd_word(a), 4'(m << a[1:0])});
  endtask

  task automatic odd_cases();
    logic [7:0] cnt;
    cnt = wr_count;
    i_pre_alu_exc = 1'b1;
    i_alu_req = '{valid: 1'b1, store: 1'b1, size: DDP_SZ_WORD, addr: 32'h40,
                  data: 32'h5, exc: 1'b0};
    cyc(1);
    i_pre_alu_exc = 1'b0;
    chk(o_request_valid, 1'b0);
    issue(1'b1, DDP_SZ_WORD, 32'h0001_0000, 32'h1);
    chk(o_biu_respond, 1'b1);
    chk(o_cpu_drive_request, 1'b0);
    cyc(1);
    chk(o_cpu_data_bus_oe_n, 1'b1);
    cyc(1);
    chk(wr_count, cnt);
  endtask

  task automatic fill_drain();
    i_load_ready = 1'b0;
    for (int k = 0; k < 3; k++) begin
      i_alu_req = '{1'b1, 1'b0, DDP_SZ_WORD, 32'h100 + 32'(4*k), 32'h0, 1'b0};
      cyc(1);
    end
    i_alu_req = '0;
    cyc(2);
    chk(o_pipeline_stall_n, 1'b0);
    i_load_ready = 1'b1;
    for (int k = 0; k < 3; k++) begin
      chk(o_load.data, rd_word(32'h100 + 32'(4*k)));
      cyc(1);
    end
    chk(o_load_valid, 1'b0);
  endtask

  initial begin
    #40000;
    mismatches++;
    summarize();
  end

  initial begin
    cyc(6);
    chk(o_memory_init_reset, 1'b1);
    chk(o_cpu_data_bus_oe_n, 1'b1);
    i_sys_rst = 1'b0;
    cyc(1);
    chk(o_memory_init_reset, 1'b0);
    do_store(32'h10, 32'ha5c3_1e0f, 1'b0, 0, 0);
    do_store(32'h14, 32'h0123_4567, 1'b0, 2, 2);
    do_store(32'h18, 32'hdead_0001, 1'b1, 1, 2);
    for (int s = 0; s < 4; s++) do_load(32'h20 + 32'(s), ddp_size_t'(s), 0, 0);
    do_load(32'h30, DDP_SZ_WORD, 3, 1'b0);
    do_load(32'h34, DDP_SZ_HALF, 0, 1'b1);
    odd_cases();
    fill_drain();
    summarize();
  end
endmodule
